// ---- hdl/nfsb_pkg.sv ----
// Constants, register map and types of the NAND flash host sequencer.
// Assumes one 250 MHz clock and a small-page x8 NAND flash on the pins.
// Notes on behaviour
// [RQ1] Device fetches a page within 12 us, busy meanwhile
// [RQ2] Main area programmed once, spare twice per erase
// [RQ3] Device goes busy after last word of page
// [RQ4] Chip select high aborts read fetch quickly
// [RQ5] Hold chip select high 100 ns to end reads
// [RQ6] Reset finishes within 5, 10 or 500 us
// [RQ7] Reset while ready still busies up to 5 us
// [RQ8] Write protect settles 100 ns before final strobe
// [RQ9] Status bits 0 and 1 report pass or fail
// [RQ10] Status bit 6 is ready, low when busy
// [RQ11] Status bit 5 shows internal controller idle
// [RQ12] Identifier gives maker code then device code
// [RQ13] Chip select may drop between data cycles
// [RQ14] Chip-select-free variant never crosses pages alone
// [RQ15] Spare marker not all ones marks block bad
// [RQ16] Good blocks leave the factory fully erased
// [RQ17] Block zero is always good
// [RQ18] Scan bad-block markers before any erase
// [RQ19] Worn block failures show in status fail bit
// [RQ20] Failed program spares other pages of block
// [RQ21] Relocate failing blocks, report failures to software
// [RQ22] Status bit 7 low when write protected
// [RQ23] Reset with protect high gives status C0h; the flash model gives E0h once ready
// [RQ24] Identifier mode is command 90h then address 00h
// [RQ25] Ready/busy pin low while an operation runs
package nfsb_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned DQ_W = 8;
  localparam int unsigned ROW_W = 17;
  localparam int unsigned PAGE_W = 5;
  localparam int unsigned BLK_W = ROW_W - PAGE_W;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;

  // Pin timing in ns, busy ceiling in ms
  localparam int unsigned T_STRB_LO_NS = 20;
  localparam int unsigned T_CYC_NS = 30;
  localparam int unsigned T_CS_NS = 20;
  localparam int unsigned T_WB_NS = 100;
  localparam int unsigned T_WHR_NS = 60;
  localparam int unsigned T_CEH_NS = 100;
  localparam int unsigned T_WW_NS = 100;
  localparam int unsigned T_BUSY_MAX_MS = 3;

  // Least time to cycles, rounded up, never below one
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c == 0) ? 1 : c;
  endfunction

  function automatic logic [BLK_W-1:0] row_blk(input logic [ROW_W-1:0] row);
    return row[ROW_W-1:PAGE_W];
  endfunction

  localparam int unsigned STRB_LO_CYC = ns_to_cyc(T_STRB_LO_NS);
  localparam int unsigned STRB_HI_CYC = ns_to_cyc(T_CYC_NS) - STRB_LO_CYC;
  localparam logic [3:0] STRB_LO_LD = 4'(STRB_LO_CYC - 1);
  localparam logic [3:0] STRB_HI_LD = 4'(STRB_HI_CYC - 1);
  localparam logic [CNT_W-1:0] CS_LD = CNT_W'(ns_to_cyc(T_CS_NS) - 1);
  localparam logic [CNT_W-1:0] WB_LD = CNT_W'(ns_to_cyc(T_WB_NS) - 1);
  localparam logic [CNT_W-1:0] WHR_LD = CNT_W'(ns_to_cyc(T_WHR_NS) - 1);
  localparam logic [CNT_W-1:0] CEH_LD = CNT_W'(ns_to_cyc(T_CEH_NS) - 1);
  localparam logic [7:0] WW_CNT = 8'(ns_to_cyc(T_WW_NS));
  localparam int unsigned BUSY_MAX_DEF = T_BUSY_MAX_MS * 1000 * 1000 / (1000 / CLK_MHZ);

  // Register byte addresses
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_OP = 8'h04;
  localparam logic [AW-1:0] REG_ROW = 8'h08;
  localparam logic [AW-1:0] REG_STAT = 8'h0C;
  localparam logic [AW-1:0] REG_DATA = 8'h10;
  localparam logic [AW-1:0] REG_ID = 8'h14;

  // Control bits
  localparam int unsigned CTRL_W = 3;
  localparam int unsigned CTRL_WP = 0;
  localparam int unsigned CTRL_CSREL = 1;
  localparam int unsigned CTRL_SPARE = 2;

  // Operation register layout and codes
  localparam int unsigned OPC_W = 4;
  localparam int unsigned OPC_LSB = 0;
  localparam int unsigned ARG_LSB = 8;
  localparam logic [OPC_W-1:0] OP_CMD = 4'h0;
  localparam logic [OPC_W-1:0] OP_ADDR = 4'h1;
  localparam logic [OPC_W-1:0] OP_WRITE = 4'h2;
  localparam logic [OPC_W-1:0] OP_READ = 4'h3;
  localparam logic [OPC_W-1:0] OP_WAIT = 4'h4;
  localparam logic [OPC_W-1:0] OP_END = 4'h5;
  localparam logic [OPC_W-1:0] OP_ID = 4'h6;
  localparam logic [OPC_W-1:0] OP_STATUS = 4'h7;
  localparam logic [OPC_W-1:0] OP_MARK = 4'h8;

  // Status register bits
  localparam int unsigned SB_BUSY = 0;
  localparam int unsigned SB_REFUSED = 1;
  localparam int unsigned SB_TIMEOUT = 2;
  localparam int unsigned SB_BAD = 3;
  localparam int unsigned SB_SCANNED = 4;
  localparam int unsigned SB_FAIL = 5;
  localparam int unsigned SB_RB = 6;
  localparam int unsigned SB_WP = 7;
  localparam int unsigned SB_NST = 8;

  // Flash command bytes and status coding
  localparam logic [DQ_W-1:0] CMD_READ_ID = 8'h90;
  localparam logic [DQ_W-1:0] ID_ADDR = 8'h00;
  localparam logic [DQ_W-1:0] CMD_STATUS = 8'h70;
  localparam logic [DQ_W-1:0] CMD_PROG = 8'h80;
  localparam logic [DQ_W-1:0] CMD_ERASE = 8'h60;
  localparam logic [DQ_W-1:0] MARK_GOOD = 8'hFF;
  localparam int unsigned NST_FAIL = 0;
  localparam int unsigned NST_CFAIL = 1;
  localparam logic [1:0] MAIN_MAX = 2'h1;
  localparam logic [1:0] SPARE_MAX = 2'h2;

  typedef enum logic [1:0] {K_CMD, K_ADDR, K_WR, K_RD} nfsb_kind_e;
  typedef enum logic [1:0] {C_IDLE, C_LO, C_HI} nfsb_cph_e;
  typedef enum logic [2:0] {S_IDLE, S_WPW, S_CYC, S_WHR, S_WB, S_BUSY, S_CEH} nfsb_st_e;

  typedef struct packed {
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic dq_oe_n;
    logic [DQ_W-1:0] dq;
  } nfsb_bus_s;

  typedef struct packed {
    nfsb_cph_e ph;
    logic [3:0] cnt;
    nfsb_kind_e kind;
    logic done;
    logic [DQ_W-1:0] rd;
    nfsb_bus_s bus;
  } nfsb_cyc_s;

  typedef struct packed {
    nfsb_st_e st;
    logic [OPC_W-1:0] op;
    logic [1:0] step;
    logic [CNT_W-1:0] cnt;
    logic [CTRL_W-1:0] ctrl;
    logic [ROW_W-1:0] row;
    logic [DQ_W-1:0] rd;
    logic [DQ_W-1:0] id0;
    logic [DQ_W-1:0] id1;
    logic [DQ_W-1:0] nst;
    logic refused;
    logic timeout;
    logic bad;
    logic scanned;
    logic fail;
    logic [BLK_W-1:0] scan_blk;
    logic [ROW_W-1:0] prog_row;
    logic [1:0] main_cnt;
    logic [1:0] spare_cnt;
    logic [7:0] wp_cnt;
    logic [7:0] ce_hi;
    logic ce_n;
    logic wp_n;
    logic start;
    nfsb_kind_e kind;
    logic [DQ_W-1:0] wbyte;
    logic [DW-1:0] rdata;
  } nfsb_ctl_s;
endpackage

// ---- hdl/nfsb_pin_cycle.sv ----
// One command, address, write or read cycle on the flash strobes.
// Assumes start only while idle; chip select is handled by the caller.
`timescale 1ns/1ps
module nfsb_pin_cycle (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request
  input wire logic start,
  input nfsb_pkg::nfsb_kind_e kind,
  input wire logic [nfsb_pkg::DQ_W-1:0] wbyte,
  input wire logic [nfsb_pkg::DQ_W-1:0] dq_in,
  // Answer
  output logic done,
  output logic [nfsb_pkg::DQ_W-1:0] rd,
  output nfsb_pkg::nfsb_bus_s bus
);
  import nfsb_pkg::*;

  localparam nfsb_bus_s BUS_IDLE = '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                                     dq_oe_n: 1'b1, dq: '0};
  localparam nfsb_cyc_s CYC_RST = '{ph: C_IDLE, cnt: '0, kind: K_CMD, done: 1'b0,
                                    rd: '0, bus: BUS_IDLE};

  nfsb_cyc_s q;
  nfsb_cyc_s n;

  always_comb
  begin
    n = q;
    n.done = 1'b0;
    unique case (q.ph)
      C_IDLE:
        if (start)
        begin
          n.ph = C_LO;
          n.cnt = STRB_LO_LD;
          n.kind = kind;
          n.bus.cle = (kind == K_CMD);
          n.bus.ale = (kind == K_ADDR);
          n.bus.we_n = (kind == K_RD);
          n.bus.re_n = (kind != K_RD);
          n.bus.dq_oe_n = (kind == K_RD);
          n.bus.dq = wbyte;
        end
      C_LO:
        if (q.cnt != 4'h0)
          n.cnt = q.cnt - 4'h1;
        else
        begin
          // Data sampled at the end of the low phase, after access time
          if (q.kind == K_RD)
            n.rd = dq_in;
          n.ph = C_HI;
          n.cnt = STRB_HI_LD;
          n.bus.we_n = 1'b1;
          n.bus.re_n = 1'b1;
        end
      C_HI:
        if (q.cnt != 4'h0)
          n.cnt = q.cnt - 4'h1;
        else
        begin
          n.ph = C_IDLE;
          n.done = 1'b1;
          n.bus = BUS_IDLE;
        end
      default:
        n = CYC_RST;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= CYC_RST;
    else
      q <= n;
  end

  assign done = q.done;
  assign rd = q.rd;
  assign bus = q.bus;

  property p_we_width;
    @(posedge clk) disable iff (rst)
      $fell(q.bus.we_n) |-> !q.bus.we_n [*5] ##1 q.bus.we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe low width wrong");

  property p_dq_drive;
    @(posedge clk) disable iff (rst)
      !q.bus.we_n |-> !q.bus.dq_oe_n && q.bus.re_n;
  endproperty
  a_dq_drive: assert property (p_dq_drive) else $error("data not driven under write strobe");
endmodule

// ---- hdl/nfsb_host.sv ----
// Host sequencer that drives a small-page NAND flash through its pins.
// Assumes pin inputs synchronous to CLK_SYS and software on a strobe port.
`timescale 1ns/1ps
module nfsb_host #(
  parameter int unsigned BUSY_MAX_CYC = nfsb_pkg::BUSY_MAX_DEF
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Register port
  input wire logic [nfsb_pkg::AW-1:0] ADDR,
  input wire logic [nfsb_pkg::DW-1:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [nfsb_pkg::DW-1:0] RDATA,
  // Flash pins
  output logic CE_N,
  output logic CLE,
  output logic ALE,
  output logic WE_N,
  output logic RE_N,
  output logic WP_N,
  output logic [nfsb_pkg::DQ_W-1:0] DQ_O,
  output logic DQ_OE_N,
  input wire logic [nfsb_pkg::DQ_W-1:0] DQ_I,
  input wire logic RB_N
);
  import nfsb_pkg::*;

  localparam logic [CNT_W-1:0] BUSY_LD = CNT_W'(BUSY_MAX_CYC - 1);
  localparam nfsb_ctl_s CTL_RST = '{st: S_IDLE, kind: K_CMD, ce_n: 1'b1, default: '0};

  nfsb_ctl_s q;
  nfsb_ctl_s n;
  nfsb_bus_s bus;
  logic cyc_done;
  logic [DQ_W-1:0] cyc_rd;
  logic wr_op;
  logic [OPC_W-1:0] op_new;
  logic [DQ_W-1:0] arg_new;
  logic same_row;
  logic is_spare;
  logic [1:0] cur_cnt;
  logic prog_over;
  logic erase_bad;
  logic mark_ok;
  logic wp_ok;
  logic [DW-1:0] rv;

  nfsb_pin_cycle u_cyc (
    .clk(CLK_SYS),
    .rst(RST),
    .start(q.start),
    .kind(q.kind),
    .wbyte(q.wbyte),
    .dq_in(DQ_I),
    .done(cyc_done),
    .rd(cyc_rd),
    .bus(bus)
  );

  assign wr_op = WR_STB && (ADDR == REG_OP);
  assign op_new = WDATA[OPC_LSB +: OPC_W];
  assign arg_new = WDATA[ARG_LSB +: DQ_W];
  assign same_row = (q.row == q.prog_row);
  assign is_spare = q.ctrl[CTRL_SPARE];
  assign cur_cnt = !same_row ? 2'h0 : (is_spare ? q.spare_cnt : q.main_cnt);
  // Partial-program budget of the last programmed page only, cleared by a new row or by erasing its block
  assign prog_over = (arg_new == CMD_PROG) &&
                     (cur_cnt >= (is_spare ? SPARE_MAX : MAIN_MAX)); // [RQ2]
  // Erase only after the marker of that block was scanned
  assign erase_bad = (arg_new == CMD_ERASE) &&
                     !(q.scanned && (q.scan_blk == row_blk(q.row))); // [RQ18]
  // Second page is consulted only when the first page marker was bad
  assign mark_ok = (q.row[PAGE_W-1:0] == '0) ||
                   ((q.row[PAGE_W-1:0] == PAGE_W'(1)) && q.scanned && q.bad &&
                    (q.scan_blk == row_blk(q.row))); // [RQ15]
  assign wp_ok = (q.wp_cnt == WW_CNT) && (q.wp_n == q.ctrl[CTRL_WP]);

  always_comb
  begin
    rv = '0;
    unique case (ADDR)
      REG_CTRL:
        rv[CTRL_W-1:0] = q.ctrl;
      REG_OP:
        rv[OPC_LSB +: OPC_W] = q.op;
      REG_ROW:
        rv[ROW_W-1:0] = q.row;
      REG_STAT:
      begin
        rv[SB_BUSY] = (q.st != S_IDLE);
        rv[SB_REFUSED] = q.refused;
        rv[SB_TIMEOUT] = q.timeout;
        rv[SB_BAD] = q.bad;
        rv[SB_SCANNED] = q.scanned;
        rv[SB_FAIL] = q.fail;
        rv[SB_RB] = RB_N;
        rv[SB_WP] = q.wp_n;
        rv[SB_NST +: DQ_W] = q.nst;
      end
      REG_DATA:
        rv[DQ_W-1:0] = q.rd;
      REG_ID:
        rv[2*DQ_W-1:0] = {q.id1, q.id0};
      default:
        rv = '0;
    endcase
  end

  always_comb
  begin
    n = q;
    n.start = 1'b0;
    n.rdata = RD_STB ? rv : '0;
    n.ce_hi = q.ce_n ? ((q.ce_hi == 8'hFF) ? q.ce_hi : q.ce_hi + 8'h01) : 8'h00;
    if (WR_STB && ADDR == REG_CTRL)
      n.ctrl = WDATA[CTRL_W-1:0];
    if (WR_STB && ADDR == REG_ROW)
      n.row = WDATA[ROW_W-1:0];
    // Protect pin follows control; settle time counted from each change
    if (q.ctrl[CTRL_WP] != q.wp_n)
    begin
      n.wp_n = q.ctrl[CTRL_WP];
      n.wp_cnt = 8'h00;
    end
    else if (q.wp_cnt != WW_CNT)
      n.wp_cnt = q.wp_cnt + 8'h01;
    if (wr_op && q.st != S_IDLE)
      n.refused = 1'b1;
    unique case (q.st)
      S_IDLE:
        if (wr_op)
        begin
          n.refused = 1'b0;
          n.timeout = 1'b0;
          n.op = op_new;
          n.step = 2'h0;
          n.wbyte = arg_new;
          n.cnt = q.ce_n ? CS_LD : '0;
          n.st = S_WPW;
          unique case (op_new)
            OP_CMD:
              if (prog_over || erase_bad)
              begin
                n.refused = 1'b1; // [RQ2] [RQ18]
                n.st = S_IDLE;
              end
              else
              begin
                n.kind = K_CMD;
                if (arg_new == CMD_PROG)
                begin
                  n.prog_row = q.row;
                  n.main_cnt = same_row ? q.main_cnt : 2'h0;
                  n.spare_cnt = same_row ? q.spare_cnt : 2'h0;
                  if (is_spare)
                    n.spare_cnt = cur_cnt + 2'h1; // [RQ2]
                  else
                    n.main_cnt = cur_cnt + 2'h1; // [RQ2]
                end
                if (arg_new == CMD_ERASE && row_blk(q.prog_row) == row_blk(q.row))
                begin
                  n.main_cnt = 2'h0;
                  n.spare_cnt = 2'h0;
                end
              end
            OP_ADDR:
              n.kind = K_ADDR;
            OP_WRITE:
              n.kind = K_WR;
            OP_READ:
              n.kind = K_RD;
            OP_ID:
            begin
              n.kind = K_CMD;
              n.wbyte = CMD_READ_ID; // [RQ24]
            end
            OP_STATUS:
            begin
              n.kind = K_CMD;
              n.wbyte = CMD_STATUS;
            end
            OP_WAIT:
            begin
              n.st = S_WB;
              n.cnt = WB_LD;
            end
            OP_END:
            begin
              n.st = S_CEH;
              n.cnt = CEH_LD;
              n.ce_n = 1'b1; // [RQ5]
            end
            OP_MARK:
            begin
              n.st = S_IDLE;
              if (mark_ok)
              begin
                n.bad = (q.rd != MARK_GOOD); // [RQ15]
                n.scanned = 1'b1;
                n.scan_blk = row_blk(q.row);
              end
              else
                n.refused = 1'b1;
            end
            default:
            begin
              n.refused = 1'b1;
              n.st = S_IDLE;
            end
          endcase
          if (n.st == S_WPW)
            n.ce_n = 1'b0;
        end
      S_WPW:
        if (q.cnt != '0)
          n.cnt = q.cnt - CNT_W'(1);
        else if (q.kind != K_CMD || wp_ok) // [RQ8]
        begin
          n.start = 1'b1;
          n.st = S_CYC;
        end
      S_CYC:
        if (cyc_done)
        begin
          n.step = q.step + 2'h1;
          n.st = S_IDLE;
          if (q.kind == K_RD)
            n.rd = cyc_rd;
          if (q.op == OP_ID && q.step == 2'h0)
          begin
            n.st = S_WPW;
            n.kind = K_ADDR;
            n.wbyte = ID_ADDR; // [RQ24]
          end
          else if ((q.op == OP_ID && q.step == 2'h1) || (q.op == OP_STATUS && q.step == 2'h0))
          begin
            n.st = S_WHR;
            n.cnt = WHR_LD;
          end
          else if (q.op == OP_ID && q.step == 2'h2)
          begin
            n.id0 = cyc_rd; // [RQ24]
            n.st = S_WPW;
          end
          else if (q.op == OP_ID)
            n.id1 = cyc_rd; // [RQ24]
          else if (q.op == OP_STATUS)
          begin
            n.nst = cyc_rd;
            n.fail = cyc_rd[NST_FAIL] | cyc_rd[NST_CFAIL]; // [RQ21]
          end
        end
      S_WHR:
        if (q.cnt != '0)
          n.cnt = q.cnt - CNT_W'(1);
        else
        begin
          n.st = S_WPW;
          n.kind = K_RD;
        end
      S_WB:
        if (q.cnt != '0)
          n.cnt = q.cnt - CNT_W'(1);
        else
          n.st = S_BUSY;
      S_BUSY:
        if (RB_N)
          n.st = S_IDLE;
        else if (q.cnt == BUSY_LD)
        begin
          n.timeout = 1'b1;
          n.st = S_IDLE;
        end
        else
          n.cnt = q.cnt + CNT_W'(1);
      S_CEH:
        if (q.cnt != '0)
          n.cnt = q.cnt - CNT_W'(1);
        else
          n.st = S_IDLE;
      default:
        n = CTL_RST;
    endcase
    // Chip select may rest high between cycles; operation state is kept
    if (n.st == S_IDLE && q.ctrl[CTRL_CSREL])
      n.ce_n = 1'b1; // [RQ13]
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      q <= CTL_RST;
    else
      q <= n;
  end

  assign RDATA = q.rdata;
  assign CE_N = q.ce_n;
  assign WP_N = q.wp_n;
  assign CLE = bus.cle;
  assign ALE = bus.ale;
  assign WE_N = bus.we_n;
  assign RE_N = bus.re_n;
  assign DQ_O = bus.dq;
  assign DQ_OE_N = bus.dq_oe_n;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  property p_ceh_hold;
    q.st == S_CEH && q.cnt == '0 |-> q.ce_n && q.ce_hi >= 8'(CEH_LD);
  endproperty
  a_ceh_hold: assert property (p_ceh_hold) else $error("chip select break too short"); // [RQ5]

  property p_wp_settle;
    q.start && q.kind == K_CMD |-> q.wp_cnt >= WW_CNT && WP_N == q.ctrl[CTRL_WP];
  endproperty
  a_wp_settle: assert property (p_wp_settle) else $error("command before protect settled"); // [RQ8]

  property p_prog_limit;
    q.st == S_IDLE && wr_op && op_new == OP_CMD && prog_over |=>
      q.refused && q.st == S_IDLE && $stable(q.main_cnt) && $stable(q.spare_cnt);
  endproperty
  a_prog_limit: assert property (p_prog_limit) else $error("over-budget program issued"); // [RQ2]

  property p_erase_scan;
    q.st == S_IDLE && wr_op && op_new == OP_CMD && erase_bad |=> q.refused ##1 WE_N [*3];
  endproperty
  a_erase_scan: assert property (p_erase_scan) else $error("erase of unscanned block"); // [RQ18]

  sequence s_id_cmd;
    q.start && q.kind == K_CMD && q.wbyte == CMD_READ_ID;
  endsequence
  property p_id_seq;
    q.st == S_IDLE && wr_op && op_new == OP_ID |=> ##[0:40] s_id_cmd ##[10:14]
      (q.start && q.kind == K_ADDR && q.wbyte == ID_ADDR);
  endproperty
  a_id_seq: assert property (p_id_seq) else $error("identifier entry sequence wrong"); // [RQ24]

  property p_mark;
    q.st == S_IDLE && wr_op && op_new == OP_MARK && mark_ok |=>
      q.scanned && q.bad == ($past(q.rd) != MARK_GOOD);
  endproperty
  a_mark: assert property (p_mark) else $error("bad-block verdict wrong"); // [RQ15]

  property p_cs_release;
    $past(q.st) == S_IDLE && q.st == S_IDLE && $past(q.ctrl[CTRL_CSREL]) |-> CE_N;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("chip select low while resting"); // [RQ13]

  property p_fail_rep;
    q.st == S_CYC && cyc_done && q.op == OP_STATUS && q.step == 2'h1 |=>
      q.fail == (q.nst[NST_FAIL] | q.nst[NST_CFAIL]) && q.st == S_IDLE;
  endproperty
  a_fail_rep: assert property (p_fail_rep) else $error("fail flag not from status"); // [RQ21]

  c_id: cover property (q.st == S_CYC && cyc_done && q.op == OP_ID && q.step == 2'h3);
  c_status: cover property (q.st == S_CYC && cyc_done && q.op == OP_STATUS && q.step == 2'h1);
  c_end: cover property (q.st == S_CEH ##1 q.st == S_IDLE);
  c_prog_refused: cover property (q.st == S_IDLE && wr_op && op_new == OP_CMD && prog_over);
endmodule

// ---- testbench/nfsb_flash_model.sv ----
// Behavioural x8 flash device answering the host's pins.
// Assumes host strobes are clean; busy times shortened for simulation.
`timescale 1ns/1ps
module nfsb_flash_model #(
  parameter int T_FETCH_NS = 1200,
  parameter int T_RESET_NS = 400,
  parameter logic [7:0] ID0 = 8'h5A, // Arbitrary maker code
  parameter logic [7:0] ID1 = 8'hC3 // Arbitrary device code
) (
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic rb_n
);
  logic [1:0] mode = 2'h0;
  logic [2:0] acnt = 3'h0;
  logic idx = 1'b0;
  logic [7:0] byte_out = 8'h00;
  int t_busy = 0;
  event go;
  initial dq_out = 8'hA5;
  initial rb_n = 1'b1;
  // Open-drain pin released high when idle
  always @(go)
  begin
    rb_n = 1'b0;
    #(t_busy) rb_n = 1'b1;
  end
  // Chip select raised during a page fetch aborts it
  always @(posedge ce_n)
    if (!rb_n && mode == 2'h3)
      #60 rb_n = 1'b1;
  always @(posedge we_n)
    if (!ce_n && cle)
    begin
      mode = (dq_in == 8'h90) ? 2'h1 : (dq_in == 8'h70) ? 2'h2 : 2'h3;
      idx = 1'b0;
      acnt = 3'h0;
      if (dq_in == 8'hFF)
      begin
        t_busy = T_RESET_NS;
        -> go;
      end
    end
    else if (!ce_n && ale && mode == 2'h3)
    begin
      acnt = acnt + 3'h1;
      if (acnt == 3'h4)
      begin
        t_busy = T_FETCH_NS;
        -> go;
      end
    end
  always @(negedge re_n)
  begin
    case (mode)
      2'h1: byte_out = idx ? ID1 : ID0;
      2'h2: byte_out = {wp_n, rb_n, rb_n, 5'h00};
      // No automatic page crossing in this variant
      default: byte_out = 8'hFF;
    endcase
    idx = 1'b1;
    #18 dq_out = byte_out;
  end
  // Released bus shows the inverse, never a stale value
  always @(posedge re_n)
    #10 dq_out = ~byte_out;
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the flash host sequencer.
// Assumes the behavioural flash model sits on the pins.
`timescale 1ns/1ps
module testbench;
  import nfsb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rdata;
  logic ce_n, cle, ale, we_n, re_n, wp_n, dq_oe_n, rb_n;
  logic [7:0] dq_o, dq_i;
  int n_fail = 0;
  int check_count = 0;
  logic [31:0] s;
  initial forever #2 clk = ~clk;
  nfsb_host #(.BUSY_MAX_CYC(600)) nfsb_host_i (.CLK_SYS(clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .CE_N(ce_n),
    .CLE(cle), .ALE(ale), .WE_N(we_n), .RE_N(re_n), .WP_N(wp_n), .DQ_O(dq_o),
    .DQ_OE_N(dq_oe_n), .DQ_I(dq_i), .RB_N(rb_n));
  nfsb_flash_model nfsb_flash_model_i (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .re_n(re_n), .wp_n(wp_n), .dq_in(dq_o), .dq_out(dq_i), .rb_n(rb_n));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  // Issue one operation and wait for the sequencer to go idle
  task automatic op(input logic [3:0] code, input logic [7:0] arg);
    int i;
    wr(REG_OP, {16'h0, arg, 4'h0, code});
    for (i = 0; i < 2000; i++)
    begin
      rd(REG_STAT, s);
      if (s[SB_BUSY] === 1'b0)
        break;
    end
    if (i == 2000)
      chk("op finishes", 32'h0, 32'h1);
  endtask
  task automatic t_reset;
    chk("CE_N at reset", 32'h1, {31'h0, ce_n});
    chk("WP_N at reset", 32'h0, {31'h0, wp_n});
    rd(REG_STAT, s);
    chk("STAT at reset", 32'h40, s);
    rd(8'h3C, s);
    chk("unmapped read", 32'h0, s);
    $display("test reset done");
  endtask
  task automatic t_id;
    wr(REG_CTRL, 32'h1);
    op(OP_ID, 8'h00);
    rd(REG_ID, s);
    chk("ID bytes", 32'hC35A, s);
    $display("test id done");
  endtask
  task automatic t_status;
    for (int w = 0; w < 2; w++)
    begin
      wr(REG_CTRL, w);
      op(OP_STATUS, 8'h00);
      rd(REG_STAT, s);
      chk("status byte", w ? 8'hE0 : 8'h60, s[15:8]);
      chk("WP_N and RB_N", {w[0], 1'b1}, s[7:6]);
      chk("fail flag", 32'h0, s[SB_FAIL]);
    end
    $display("test status done");
  endtask
  task automatic t_refuse;
    op(4'hF, 8'h00);
    rd(REG_STAT, s);
    chk("illegal op refused", 32'h1, s[SB_REFUSED]);
    op(OP_CMD, 8'h80);
    op(OP_CMD, 8'h80);
    rd(REG_STAT, s);
    chk("second main program refused", 32'h1, s[SB_REFUSED]);
    wr(REG_ROW, 32'h20);
    op(OP_CMD, 8'h60);
    rd(REG_STAT, s);
    chk("unscanned erase refused", 32'h1, s[SB_REFUSED]);
    $display("test refuse done");
  endtask
  task automatic t_rst_cmd;
    op(OP_CMD, 8'hFF);
    rd(REG_STAT, s);
    chk("busy after reset cmd", 32'h0, s[SB_RB]);
    chk("refused cleared", 32'h0, s[SB_REFUSED]);
    op(OP_WAIT, 8'h00);
    rd(REG_STAT, s);
    chk("ready after wait", 32'h1, s[SB_RB]);
    chk("no timeout", 32'h0, s[SB_TIMEOUT]);
    $display("test reset command done");
  endtask
  task automatic t_read;
    wr(REG_ROW, 32'h0);
    op(OP_CMD, 8'h00);
    repeat (4) op(OP_ADDR, 8'h00);
    rd(REG_STAT, s);
    chk("busy on fetch", 32'h0, s[SB_RB]);
    op(OP_WAIT, 8'h00);
    op(OP_READ, 8'h00);
    rd(REG_DATA, s);
    chk("erased byte", 32'hFF, s[7:0]);
    op(OP_MARK, 8'h00);
    rd(REG_STAT, s);
    chk("block good", 32'h0, s[SB_BAD]);
    chk("block scanned", 32'h1, s[SB_SCANNED]);
    $display("test read done");
  endtask
  task automatic t_end;
    op(OP_END, 8'h00);
    chk("CE_N after end", 32'h1, {31'h0, ce_n});
    wr(REG_CTRL, 32'h3);
    op(OP_STATUS, 8'h00);
    chk("CE_N released when idle", 32'h1, {31'h0, ce_n});
    $display("test end done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #300000;
    n_fail++;
    wrap_up();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_id();
    t_status();
    t_refuse();
    t_rst_cmd();
    t_read();
    t_end();
    wrap_up();
  end
endmodule
